/* clk_status_pkg.sv */
// constants for the status and first output driver register slice
`default_nettype none
package clk_status_pkg;
  // ******************************
  // register offsets
  // ******************************
  localparam int ADDR_W = 10;
  localparam logic [9:0] ADDR_STATUS = 10'h01f;
  localparam logic [9:0] ADDR_OUT_CTRL = 10'h0f0;
  // ******************************
  // status byte fields
  // ******************************
  localparam int ST_HOLDOVER = 5;
  localparam int ST_SEC_SEL = 4;
  localparam int ST_OSC_HI = 3;
  localparam int ST_SEC_HI = 2;
  localparam int ST_PRI_HI = 1;
  localparam int ST_LOCK = 0;
  localparam int ST_W = 6;
  // ******************************
  // output control fields
  // ******************************
  localparam int OC_FORMAT = 7;
  localparam int OC_LEG_B_EN = 6;
  localparam int OC_LEG_A_EN = 5;
  localparam int OC_POL_B = 4;
  localparam int OC_POL_A = 3;
  localparam int OC_CUR_HI = 2;
  localparam int OC_CUR_LO = 1;
  localparam int OC_PWR_DOWN = 0;
  localparam logic [7:0] OUT_CTRL_RESET = 8'h62;
  // decoded driver settings for the control reset value
  localparam logic [7:0] DRV_RESET = 8'h6a;
  localparam logic [7:0] RDATA_NONE = 8'h00;
endpackage
`default_nettype wire

/* drv_cfg_if.sv */
// carrier between the register slice and the driver decoder
`default_nettype none
interface drv_cfg_if;
  logic [7:0] ctrl;
  logic cmos_mode;
  logic leg_a_en;
  logic leg_b_en;
  logic leg_a_inv;
  logic leg_b_inv;
  logic [1:0] cur_sel;
  logic pwr_down;
  modport regs (output ctrl, input cmos_mode, leg_a_en, leg_b_en,
    leg_a_inv, leg_b_inv, cur_sel, pwr_down);
  modport dec (input ctrl, output cmos_mode, leg_a_en, leg_b_en,
    leg_a_inv, leg_b_inv, cur_sel, pwr_down);
endinterface
`default_nettype wire

/* out_drv_decode.sv */
// decodes the first output channel control byte into driver settings
`default_nettype none
module out_drv_decode (
  drv_cfg_if.dec cfg
);
  // ******************************
  // driver decode
  // ******************************
  always_comb begin
    cfg.cmos_mode = cfg.ctrl[clk_status_pkg::OC_FORMAT];
    cfg.pwr_down = cfg.ctrl[clk_status_pkg::OC_PWR_DOWN];
    cfg.cur_sel = cfg.ctrl[clk_status_pkg::OC_CUR_HI:
      clk_status_pkg::OC_CUR_LO];
    cfg.leg_a_inv = cfg.ctrl[clk_status_pkg::OC_POL_A];
    if (cfg.cmos_mode) begin
      cfg.leg_a_en = cfg.ctrl[clk_status_pkg::OC_LEG_A_EN];
      cfg.leg_b_en = cfg.ctrl[clk_status_pkg::OC_LEG_B_EN];
      cfg.leg_b_inv = cfg.ctrl[clk_status_pkg::OC_POL_A] ^
        cfg.ctrl[clk_status_pkg::OC_POL_B];
    end else begin
      cfg.leg_a_en = 1'b1;
      cfg.leg_b_en = 1'b1;
      cfg.leg_b_inv = ~cfg.ctrl[clk_status_pkg::OC_POL_A];
    end
    if (cfg.pwr_down) begin
      cfg.leg_a_en = 1'b0;
      cfg.leg_b_en = 1'b0;
    end
  end
endmodule
`default_nettype wire

/* clock_status_output_driver_regs.sv */
// status byte and first output driver control register slice
// Summary of operation
// - status bit 5 shows holdover state active
// - status bit 4 shows secondary reference selected
// - status bit 3 shows oscillator above threshold
// - status bit 2 shows secondary reference above threshold
// - status bit 1 shows primary reference above threshold
// - status bit 0 shows digital lock
// - control bit 7 selects differential or single-ended
// - bits 2:1 select differential drive current
// - bit 0 powers the driver down
`default_nettype none
module clock_status_output_driver_regs (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [9:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // live status from loop and monitors
  input wire logic holdover_active,
  input wire logic secondary_reference_selected,
  input wire logic osc_above_threshold,
  input wire logic secondary_reference_above_threshold,
  input wire logic primary_reference_above_threshold,
  input wire logic digital_lock,
  // first output channel driver settings
  output logic cmos_mode,
  output logic leg_a_enable,
  output logic leg_b_enable,
  output logic leg_a_invert,
  output logic leg_b_invert,
  output logic [1:0] drive_current_sel,
  output logic driver_power_down
);
  // ******************************
  // status synchronisers
  // ******************************
  logic [5:0] status_in;
  logic [5:0] sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
  always_comb begin
    status_in[clk_status_pkg::ST_HOLDOVER] = holdover_active;
    status_in[clk_status_pkg::ST_SEC_SEL] =
      secondary_reference_selected;
    status_in[clk_status_pkg::ST_OSC_HI] = osc_above_threshold;
    status_in[clk_status_pkg::ST_SEC_HI] =
      secondary_reference_above_threshold;
    status_in[clk_status_pkg::ST_PRI_HI] =
      primary_reference_above_threshold;
    status_in[clk_status_pkg::ST_LOCK] = digital_lock;
    nxt_sync1 = status_in;
    nxt_sync2 = sync1_ff;
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_ff <= 6'h00;
      sync2_ff <= 6'h00;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end
  // ******************************
  // register file
  // ******************************
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [7:0] rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (reg_wr && reg_addr == clk_status_pkg::ADDR_OUT_CTRL) begin
      nxt_ctrl = reg_wdata;
    end
    // status offset has no storage, writes there fall away
    nxt_rvalid = reg_rd;
    nxt_rdata = clk_status_pkg::RDATA_NONE;
    if (reg_rd) begin
      case (reg_addr)
        clk_status_pkg::ADDR_STATUS: begin
          nxt_rdata = {2'h0, sync2_ff};
        end
        clk_status_pkg::ADDR_OUT_CTRL: begin
          nxt_rdata = ctrl_ff;
        end
        default: begin
          nxt_rdata = clk_status_pkg::RDATA_NONE;
        end
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_ff <= clk_status_pkg::OUT_CTRL_RESET;
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end
  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;
  // ******************************
  // driver decode and output registers
  // ******************************
  drv_cfg_if cfg ();
  assign cfg.ctrl = ctrl_ff;
  out_drv_decode u_dec (
    .cfg(cfg)
  );
  logic [7:0] drv_ff, nxt_drv;
  always_comb begin
    nxt_drv = {cfg.cmos_mode, cfg.leg_a_en, cfg.leg_b_en, cfg.leg_a_inv,
      cfg.leg_b_inv, cfg.cur_sel, cfg.pwr_down};
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      drv_ff <= clk_status_pkg::DRV_RESET;
    end else begin
      drv_ff <= nxt_drv;
    end
  end
  assign cmos_mode = drv_ff[7];
  assign leg_a_enable = drv_ff[6];
  assign leg_b_enable = drv_ff[5];
  assign leg_a_invert = drv_ff[4];
  assign leg_b_invert = drv_ff[3];
  assign drive_current_sel = drv_ff[2:1];
  assign driver_power_down = drv_ff[0];
  // ******************************
  // assertions
  // ******************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [1:0] rst_hist_ff, nxt_rst_hist;
  logic rd_st;
  always_comb begin
    nxt_rst_hist = {rst_hist_ff[0], reset};
  end
  always_ff @(posedge clk) begin
    rst_hist_ff <= nxt_rst_hist;
  end
  // status reads only once both sync stages are out of reset
  assign rd_st = reg_rd && reg_addr == clk_status_pkg::ADDR_STATUS &&
    rst_hist_ff == 2'h0;
  property p_holdover;
    rd_st |=> reg_rdata[5] == $past(holdover_active, 3);
  endproperty
  a_holdover: assert property (p_holdover)
    else $error("holdover bit");
  property p_sec_sel;
    rd_st |=> reg_rdata[4] == $past(secondary_reference_selected, 3);
  endproperty
  a_sec_sel: assert property (p_sec_sel)
    else $error("ref select bit");
  property p_osc_hi;
    !osc_above_threshold [*3] ##0 rd_st |=> !reg_rdata[3] && reg_rvalid;
  endproperty
  a_osc_hi: assert property (p_osc_hi)
    else $error("osc bit");
  property p_sec_hi;
    rd_st |=> reg_rdata[2] == $past(secondary_reference_above_threshold, 3);
  endproperty
  a_sec_hi: assert property (p_sec_hi)
    else $error("sec ref bit");
  property p_pri_hi;
    rd_st |=> reg_rdata[1] == $past(primary_reference_above_threshold, 3);
  endproperty
  a_pri_hi: assert property (p_pri_hi)
    else $error("pri ref bit");
  property p_lock;
    rd_st |=> reg_rdata[0] == $past(digital_lock, 3) && reg_rdata[7:6] == 2'h0;
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock bit");
  property p_format;
    reg_wr && reg_addr == clk_status_pkg::ADDR_OUT_CTRL
      |=> ##1 cmos_mode == $past(reg_wdata[7], 2);
  endproperty
  a_format: assert property (p_format)
    else $error("format");
  property p_legs;
    ctrl_ff[7] && !ctrl_ff[0] |=> leg_a_enable == $past(ctrl_ff[5]) &&
      leg_b_enable == $past(ctrl_ff[6]);
  endproperty
  a_legs: assert property (p_legs)
    else $error("leg enables");
  property p_pol;
    1'h1 |=> leg_a_invert == $past(ctrl_ff[3]) &&
      leg_b_invert == ($past(ctrl_ff[7]) ?
      $past(ctrl_ff[3] ^ ctrl_ff[4]) : !$past(ctrl_ff[3]));
  endproperty
  a_pol: assert property (p_pol)
    else $error("polarity");
  property p_cur;
    1'h1 |=> drive_current_sel == $past(ctrl_ff[2:1]);
  endproperty
  a_cur: assert property (p_cur)
    else $error("drive current");
  property p_pd;
    ctrl_ff[0] |=> driver_power_down && !leg_a_enable && !leg_b_enable;
  endproperty
  a_pd: assert property (p_pd)
    else $error("power down");
  property p_ro;
    reg_wr && reg_addr == clk_status_pkg::ADDR_STATUS |=> $stable(ctrl_ff);
  endproperty
  a_ro: assert property (p_ro)
    else $error("status write stored");
  property p_rd_answer;
    reg_rd |=> reg_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer");
  property p_idle_rdata;
    !reg_rd |=> !reg_rvalid && reg_rdata == clk_status_pkg::RDATA_NONE;
  endproperty
  a_idle_rdata: assert property (p_idle_rdata)
    else $error("idle read data");
  c_status_rd: cover property (rd_st ##1 reg_rdata[0]);
  c_holdover: cover property (rd_st ##1 reg_rdata[5]);
  c_cmos: cover property (cmos_mode && leg_a_enable && !leg_b_enable);
  c_pd: cover property (driver_power_down);
  c_lvds_swap: cover property (!cmos_mode && leg_a_invert);
endmodule
`default_nettype wire

/* clock_status_output_driver_regs_tb.sv */
// self-checking bench for the status and output driver register slice
`default_nettype none
module clock_status_output_driver_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ******************************
  // stimulus and observation
  // ******************************
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [9:0] reg_addr = 10'h000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic [5:0] st = 6'h00;
  logic cmos_mode, leg_a_enable, leg_b_enable, leg_a_invert, leg_b_invert;
  logic [1:0] drive_current_sel;
  logic driver_power_down;
  logic [7:0] drv;
  int n_errors = 0;
  int n_checks = 0;
  assign drv = {cmos_mode, leg_a_enable, leg_b_enable, leg_a_invert,
    leg_b_invert, drive_current_sel, driver_power_down};
  always #5 clk = ~clk;
  clock_status_output_driver_regs u_dut (
    .clk(clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .holdover_active(st[5]), .secondary_reference_selected(st[4]),
    .osc_above_threshold(st[3]),
    .secondary_reference_above_threshold(st[2]),
    .primary_reference_above_threshold(st[1]), .digital_lock(st[0]),
    .cmos_mode(cmos_mode), .leg_a_enable(leg_a_enable),
    .leg_b_enable(leg_b_enable), .leg_a_invert(leg_a_invert),
    .leg_b_invert(leg_b_invert), .drive_current_sel(drive_current_sel),
    .driver_power_down(driver_power_down)
  );
  // ******************************
  // helpers
  // ******************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic reg_write(input logic [9:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic reg_read(input logic [9:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
    check({7'h00, reg_rvalid}, 8'h01);
  endtask
  function automatic logic [7:0] drv_exp(input logic [7:0] v);
    logic a_en, b_en, a_inv, b_inv;
    a_en = v[7] ? v[5] : 1'b1;
    b_en = v[7] ? v[6] : 1'b1;
    a_inv = v[3];
    b_inv = v[7] ? (v[3] ^ v[4]) : ~v[3];
    if (v[0]) begin
      a_en = 1'b0;
      b_en = 1'b0;
    end
    return {v[7], a_en, b_en, a_inv, b_inv, v[2:1], v[0]};
  endfunction
  // ******************************
  // main sequence
  // ******************************
  initial begin
    logic [7:0] rd;
    repeat (20) @(negedge clk);
    check(drv, drv_exp(8'h62));
    check(reg_rdata, 8'h00);
    check({7'h00, reg_rvalid}, 8'h00);
    reset = 1'b0;
    reg_read(clk_status_pkg::ADDR_OUT_CTRL, rd);
    check(rd, 8'h62);
    check(drv, drv_exp(8'h62));
    for (int i = 0; i < 8; i++) begin
      st = (i < 6) ? (6'h01 << i) : ((i == 6) ? 6'h3f : 6'h00);
      repeat (3) @(negedge clk);
      reg_read(clk_status_pkg::ADDR_STATUS, rd);
      check(rd, {2'h0, st});
    end
    st = 6'h15;
    repeat (3) @(negedge clk);
    reg_write(clk_status_pkg::ADDR_STATUS, 8'hea);
    reg_read(clk_status_pkg::ADDR_STATUS, rd);
    check(rd, 8'h15);
    reg_read(clk_status_pkg::ADDR_OUT_CTRL, rd);
    check(rd, 8'h62);
    for (int v = 0; v < 256; v++) begin
      reg_write(clk_status_pkg::ADDR_OUT_CTRL, 8'(v));
      check(drv, drv_exp(8'(v)));
      reg_read(clk_status_pkg::ADDR_OUT_CTRL, rd);
      check(rd, 8'(v));
    end
    reg_write(10'h0f1, 8'h00);
    reg_write(10'h2f0, 8'h00);
    check(drv, drv_exp(8'hff));
    reg_read(10'h0f1, rd);
    check(rd, 8'h00);
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
